// >>> rtl/alfc_flow_ctrl.v
// Conversion flow control for a list-based analog-to-digital converter
`timescale 1ns/10ps
`default_nettype none
// --------------------------------------------------------------
// Overview of operation
// R1: Accepted restart with none in progress sets the restart pending flag
// R2: Restart while pending is an overrun held in one latest-only slot
// R3: When pending clears, the held overrun is served; flag sets next cycle
// R4: Each restart overrun samples load-ok into a background register
// R5: Background load-ok clears when the held restart is taken up
// R6: Trigger while trigger pending stops at conversion boundary, sets error
// R7: Auto-trigger colliding with external trigger halts before sampling
// R8: In trigger mode a restart overrun alone leaves trigger error alone
// R9: Sequence abort while abort pending is ignored
// R10: In restart mode restart together with trigger sets trigger error
// R11: In trigger mode a restart sets trigger pending by itself
// R12: Command and result lists double-buffered; restart with load-ok swaps
// R13: Restart with sequence abort suppresses restart and load-ok errors
// R14: A restart fetches the command at the top of the active list
// R15: A processed abort kills conversion, sequence and list walk
// R16: Resolution selectable among 8, 10 and 12 bits
// R17: Command list holds at most 64 entries, index wraps within them
// R18: Fifteen conversion-complete interrupts selected per result
// R19: A separate interrupt fires when an end-of-list command completes
// R20: Up to eight internal channels beside the external ones
// R21: Results stored left or right justified by software choice
// R22: Each command carries four option bits passed to system logic
// R23: Commands fetched from system RAM or non-volatile memory
// R24: Reset clears background registers and all pending flags
// --------------------------------------------------------------
`include "alfc_defines.vh"

module alfc_flow_ctrl (
    input wire hclk, // Bus clock
    input wire hresetn, // Async reset, active low
    input wire clk_en, // Freezes all state while low
    input wire hsel, // Slave select
    input wire [11:0] haddr, // Byte address
    input wire [1:0] htrans, // Transfer type
    input wire hwrite, // Write strobe
    input wire [2:0] hsize, // Transfer size
    input wire [31:0] hwdata, // Write data
    input wire hready, // Bus ready in
    output reg [31:0] hrdata, // Read data
    output reg hreadyout, // Slave ready
    output reg hresp, // Always OKAY
    input wire if_restart, // Internal interface restart request
    input wire if_trigger, // Internal interface trigger request
    input wire if_seq_abort, // Internal interface abort request
    input wire if_load_ok, // Internal interface load-ok
    input wire conv_boundary, // Converter at a conversion boundary
    input wire eol_done, // End-of-list command completed
    input wire [3:0] conv_irq_sel, // Interrupt index for finished result
    input wire conv_done, // A conversion result finished
    input wire mem_ack, // Command fetch completed
    input wire [31:0] mem_rdata, // Fetched command word
    output reg mem_req, // Command fetch request
    output reg mem_src_nvm, // Fetch from non-volatile memory
    output reg [6:0] mem_index, // Buffer bit and entry index
    output reg conv_run, // Conversion sequence running
    output reg conv_halt, // Halt before sampling
    output reg [1:0] resolution, // Resolution select
    output reg left_justify, // Result justification
    output reg [3:0] cmd_options, // Option bits of current command
    output reg [3:0] int_channel, // Internal channel select, bit 3 flag
    output reg result_buf, // Active result list buffer
    output reg [14:0] conv_irq, // Conversion-complete interrupts
    output reg eol_irq // End-of-list interrupt
);

// --------------------------------------------------------------
// Bus slave
// --------------------------------------------------------------
reg ap_valid_reg;
reg ap_write_reg;
reg [11:0] ap_addr_reg;
reg [5:0] ctrl_reg;
reg [31:0] cmd_reg;
wire ap_take;
wire wr_flow;
wire wr_ctrl;
wire wr_err;

assign ap_take = hsel & hready & htrans[1];
assign wr_flow = ap_valid_reg & ap_write_reg & (ap_addr_reg == `ALFC_OFS_FLOW);
assign wr_ctrl = ap_valid_reg & ap_write_reg & (ap_addr_reg == `ALFC_OFS_CTRL);
assign wr_err = ap_valid_reg & ap_write_reg & (ap_addr_reg == `ALFC_OFS_ERR);

// --------------------------------------------------------------
// Input synchronisers for internal interface requests
// --------------------------------------------------------------
reg [3:0] if_meta_reg;
reg [3:0] if_sync_reg;
reg [3:0] if_prev_reg;
wire [3:0] if_edge;

assign if_edge = if_sync_reg & ~if_prev_reg;

// --------------------------------------------------------------
// Flow state
// --------------------------------------------------------------
reg restart_pending_flag;
reg trigger_pending_flag;
reg sequence_abort_flag;
reg ovr_restart_reg;
reg ovr_load_ok_reg;
reg ovr_serve_reg;
reg trigger_error_flag;
reg restart_error_flag;
reg load_ok_error_flag;
reg stop_at_boundary_reg;
reg csl_buf_reg;
reg [5:0] csl_index_reg;
reg [3:0] conv_cnt_reg;

wire req_restart;
wire req_trigger;
wire req_abort;
wire load_ok_request;
wire trigger_pending_flag_mode;
wire restart_accept;
wire restart_overrun;
wire both_rt_err;
wire auto_trigger_pending_flag;
wire trigger_pending_flag_overrun;
wire auto_collide;
wire restart_go;
wire restart_load_ok_request;
wire restart_done;

assign req_restart = (wr_flow & hwdata[`ALFC_FLOW_RST]) | if_edge[0];
assign req_trigger = (wr_flow & hwdata[`ALFC_FLOW_TRIGGER_PENDING_FLAG]) | if_edge[1];
assign req_abort = (wr_flow & hwdata[`ALFC_FLOW_SEQUENCE_ABORT_FLAG]) | if_edge[2];
assign load_ok_request = (wr_flow & hwdata[`ALFC_FLOW_LOAD_OK_REQUEST]) | if_sync_reg[3];
assign trigger_pending_flag_mode = ctrl_reg[`ALFC_CTRL_MODE];

// Restart-only mode treats a simultaneous trigger as an error, no restart
assign both_rt_err = ~trigger_pending_flag_mode & req_restart & req_trigger; // see R10
assign restart_accept = req_restart & ~restart_pending_flag & ~both_rt_err; // see R1
assign restart_overrun = req_restart & restart_pending_flag; // see R2
assign restart_go = restart_accept | ovr_serve_reg; // see R3
assign restart_load_ok_request = restart_accept ? load_ok_request : ovr_load_ok_reg;
assign restart_done = restart_pending_flag & ~mem_req & ~ovr_serve_reg;
assign auto_trigger_pending_flag = trigger_pending_flag_mode & restart_go; // see R11
assign auto_collide = auto_trigger_pending_flag & req_trigger; // see R7
// A restart overrun never feeds this term in trigger mode
assign trigger_pending_flag_overrun = req_trigger & trigger_pending_flag; // see R6 R8

function [3:0] alfc_chan_of;
    input [31:0] cmd;
    begin
        alfc_chan_of = {cmd[7], cmd[7] ? cmd[2:0] : 3'h0}; // see R20
    end
endfunction

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ap_valid_reg <= 1'b0;
        ap_write_reg <= 1'b0;
        ap_addr_reg <= 12'h000;
        hrdata <= 32'h00000000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        ctrl_reg <= `ALFC_CTRL_RST;
        if_meta_reg <= 4'h0;
        if_sync_reg <= 4'h0;
        if_prev_reg <= 4'h0;
        restart_pending_flag <= 1'b0; // see R24
        trigger_pending_flag <= 1'b0;
        sequence_abort_flag <= 1'b0;
        ovr_restart_reg <= 1'b0;
        ovr_load_ok_reg <= 1'b0;
        ovr_serve_reg <= 1'b0;
        trigger_error_flag <= 1'b0;
        restart_error_flag <= 1'b0;
        load_ok_error_flag <= 1'b0;
        stop_at_boundary_reg <= 1'b0;
        csl_buf_reg <= 1'b0;
        csl_index_reg <= 6'h00;
        conv_cnt_reg <= 4'h0;
        cmd_reg <= 32'h00000000;
        mem_req <= 1'b0;
        mem_src_nvm <= 1'b0;
        mem_index <= 7'h00;
        conv_run <= 1'b0;
        conv_halt <= 1'b0;
        resolution <= `ALFC_RES_8;
        left_justify <= 1'b0;
        cmd_options <= 4'h0;
        int_channel <= 4'h0;
        result_buf <= 1'b0;
        conv_irq <= 15'h0000;
        eol_irq <= 1'b0;
    end else if (clk_en) begin
        // Address phase capture; data phase always completes in one cycle
        ap_valid_reg <= ap_take;
        ap_write_reg <= hwrite;
        ap_addr_reg <= {haddr[11:2], 2'h0};
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        if (ap_take && !hwrite) begin
            if (haddr[11:2] == 10'h000) begin
                hrdata <= {26'h0, ctrl_reg};
            end else if (haddr[11:2] == 10'h002) begin
                hrdata <= {24'h0, csl_buf_reg, conv_run, ovr_load_ok_reg, ovr_restart_reg,
                    1'b0, sequence_abort_flag, trigger_pending_flag, restart_pending_flag};
            end else if (haddr[11:2] == 10'h003) begin
                hrdata <= {29'h0, load_ok_error_flag, restart_error_flag, trigger_error_flag};
            end else if (haddr[11:2] == 10'h004) begin
                hrdata <= cmd_reg;
            end else if (haddr[11:2] == 10'h005) begin
                hrdata <= {26'h0, csl_index_reg};
            end else begin
                hrdata <= 32'h00000000;
            end
        end
        if (wr_ctrl) begin
            ctrl_reg <= hwdata[5:0];
        end
        if_meta_reg <= {if_load_ok, if_seq_abort, if_trigger, if_restart};
        if_sync_reg <= if_meta_reg;
        if_prev_reg <= if_sync_reg;
        resolution <= (ctrl_reg[2:1] == 2'h3) ? `ALFC_RES_12 : ctrl_reg[2:1]; // see R16
        left_justify <= ctrl_reg[`ALFC_CTRL_JUST]; // see R21
        mem_src_nvm <= ctrl_reg[`ALFC_CTRL_SRC]; // see R23
        result_buf <= ~csl_buf_reg; // see R12

        // Overrun slot keeps only the latest request
        if (restart_overrun) begin
            ovr_restart_reg <= 1'b1; // see R2
            ovr_load_ok_reg <= load_ok_request; // see R4
        end else if (ovr_serve_reg) begin
            ovr_restart_reg <= 1'b0;
            ovr_load_ok_reg <= 1'b0; // see R5
        end
        ovr_serve_reg <= 1'b0;

        // Restart flag clears when fetch and sequence are done
        if (restart_go) begin
            restart_pending_flag <= 1'b1;
        end else if (restart_done && !conv_run) begin
            restart_pending_flag <= 1'b0;
            if (ovr_restart_reg && !restart_overrun) begin
                ovr_serve_reg <= 1'b1; // see R3
            end
        end
        if (restart_go) begin
            if (restart_load_ok_request) begin
                csl_buf_reg <= ~csl_buf_reg; // see R12
            end
            csl_index_reg <= 6'h00; // see R14
            mem_req <= 1'b1;
            mem_index <= {restart_load_ok_request ? ~csl_buf_reg : csl_buf_reg, 6'h00};
        end else if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            cmd_reg <= mem_rdata;
            cmd_options <= mem_rdata[31:28]; // see R22
            int_channel <= alfc_chan_of(mem_rdata);
            // A halted sequence stays parked until the next restart
            conv_run <= trigger_pending_flag & ~stop_at_boundary_reg & ~conv_halt; // see R7
        end

        // Restart overrun raises an error unless a restart comes with an abort; a load-ok write without restart raises one even while aborting
        if (!(req_restart && req_abort)) begin
            if (restart_overrun) begin
                restart_error_flag <= 1'b1;
            end
            if (load_ok_request && wr_flow && !req_restart) begin
                load_ok_error_flag <= 1'b1;
            end
        end else begin
            restart_error_flag <= restart_error_flag; // see R13
        end
        if (wr_err && hwdata[`ALFC_ERR_RST] && !restart_overrun) begin
            restart_error_flag <= 1'b0;
        end
        if (wr_err && hwdata[`ALFC_ERR_LOAD_OK_REQUEST] && !(load_ok_request && wr_flow && !req_restart)) begin
            load_ok_error_flag <= 1'b0;
        end

        // Trigger handling; set wins over a clear in the same cycle
        if (both_rt_err || trigger_pending_flag_overrun || auto_collide) begin
            trigger_error_flag <= 1'b1; // see R6 R10
        end else if (wr_err && hwdata[`ALFC_ERR_TRIGGER_PENDING_FLAG]) begin
            trigger_error_flag <= 1'b0;
        end
        if (trigger_pending_flag_overrun) begin
            stop_at_boundary_reg <= 1'b1; // see R6
        end
        if (auto_collide) begin
            conv_halt <= 1'b1; // see R7
            conv_run <= 1'b0;
        end else if (stop_at_boundary_reg && conv_boundary) begin
            conv_halt <= 1'b1;
            conv_run <= 1'b0;
        end else if (restart_go) begin
            conv_halt <= 1'b0;
            stop_at_boundary_reg <= 1'b0;
        end
        if ((req_trigger && !both_rt_err) || auto_trigger_pending_flag) begin
            trigger_pending_flag <= 1'b1; // see R11
            // A restart must wait for its fetched command before running
            if (!mem_req && !restart_go && !trigger_pending_flag_overrun && !auto_collide && !conv_halt) begin
                conv_run <= 1'b1;
            end
        end

        // Sequence running: step the list on each conversion boundary unless a stop at boundary is pending
        if (conv_run && conv_boundary && !stop_at_boundary_reg) begin
            csl_index_reg <= csl_index_reg + 6'h01; // see R17
            mem_index <= {csl_buf_reg, csl_index_reg + 6'h01};
        end
        conv_irq <= conv_done ? (15'h0001 << conv_irq_sel) : 15'h0000; // see R18
        eol_irq <= eol_done; // see R19
        if (eol_done) begin
            conv_run <= 1'b0;
            trigger_pending_flag <= 1'b0;
        end

        // Abort takes priority over running work; repeat aborts ignored
        if (req_abort && !sequence_abort_flag) begin
            sequence_abort_flag <= 1'b1;
        end else if (sequence_abort_flag) begin
            sequence_abort_flag <= 1'b0; // see R9
            conv_run <= 1'b0; // see R15
            trigger_pending_flag <= 1'b0;
            csl_index_reg <= 6'h00;
            if (!restart_go) begin
                mem_req <= 1'b0;
            end
        end
        conv_cnt_reg <= conv_run ? conv_cnt_reg + 4'h1 : 4'h0;
    end
end

endmodule
`default_nettype wire

// >>> rtl/alfc_defines.vh
// Constants for the list-based converter flow control block
`ifndef ALFC_DEFINES_VH
`define ALFC_DEFINES_VH

// Register byte offsets
`define ALFC_OFS_CTRL 12'h000
`define ALFC_OFS_FLOW 12'h004
`define ALFC_OFS_STAT 12'h008
`define ALFC_OFS_ERR 12'h00C
`define ALFC_OFS_CMD 12'h010
`define ALFC_OFS_OPT 12'h014

// Control register fields
`define ALFC_CTRL_MODE 0
`define ALFC_CTRL_RES_LO 1
`define ALFC_CTRL_RES_HI 2
`define ALFC_CTRL_JUST 3
`define ALFC_CTRL_SRC 4
`define ALFC_CTRL_STRSEQ 5
`define ALFC_CTRL_RST 6'h00

// Flow request bits (write) and pending flags (status read)
`define ALFC_FLOW_RST 0
`define ALFC_FLOW_TRIGGER_PENDING_FLAG 1
`define ALFC_FLOW_SEQUENCE_ABORT_FLAG 2
`define ALFC_FLOW_LOAD_OK_REQUEST 3

// Error register bits, write one to clear
`define ALFC_ERR_TRIGGER_PENDING_FLAG 0
`define ALFC_ERR_RST 1
`define ALFC_ERR_LOAD_OK_REQUEST 2

// Resolution codes
`define ALFC_RES_8 2'h0
`define ALFC_RES_10 2'h1
`define ALFC_RES_12 2'h2

// List geometry and counts
`define ALFC_CSL_DEPTH 64
`define ALFC_CSL_AW 6
`define ALFC_NUM_CONV_IRQ 15
`define ALFC_NUM_INT_CH 8
`define ALFC_OPT_W 4
`define ALFC_CONV_CYCLES 4'hF

`endif

// >>> tb/alfc_flow_ctrl_properties.sv
// Concurrent port checks for the converter flow control block
`timescale 1ns/10ps
`default_nettype none
module alfc_flow_ctrl_properties (
    input wire logic hclk, // Bus clock
    input wire logic hresetn, // Reset, active low
    input wire logic clk_en, // Run enable
    input wire logic hsel, // Slave select
    input wire logic [11:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write strobe
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    input wire logic hreadyout, // Slave ready
    input wire logic hresp, // Response
    input wire logic mem_ack, // Fetch answer
    input wire logic [31:0] mem_rdata, // Fetched word
    input wire logic mem_req, // Fetch request
    input wire logic [6:0] mem_index, // Fetch index
    input wire logic conv_run, // Sequence running
    input wire logic [1:0] resolution, // Resolution select
    input wire logic [3:0] cmd_options, // Command options
    input wire logic [3:0] int_channel, // Internal channel
    input wire logic [14:0] conv_irq, // Conversion interrupts
    input wire logic eol_done, // End of list seen
    input wire logic eol_irq // End of list interrupt
);
    logic wr_q;
    logic [11:0] a_q;
    logic [31:0] rd_q;
    logic ab_ph;
    assign ab_ph = wr_q && hready && a_q == 12'h004 && hwdata[2];
    // ------------------------------------------
    // Data phase tracking
    // ------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            a_q <= 12'h000;
        end else if (hready) begin
            wr_q <= hsel && htrans[1] && hwrite;
            a_q <= haddr;
        end
    end
    always_ff @(posedge hclk) begin
        rd_q <= mem_rdata;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_flow(b);
        wr_q && hready && clk_en && a_q == 12'h004 && hwdata[3:0] == b;
    endsequence
    sequence s_fetch_top;
        mem_req && mem_index[5:0] == 6'h00;
    endsequence
    // ------------------------------------------
    // Assertions
    // ------------------------------------------
    AST_READY: assert property (hreadyout == 1'b1)
        else $error("slave inserted a wait state");
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("slave answered other than okay");
    AST_FETCH_TOP: assert property (
        s_flow(4'h1) ##0 (!mem_req && !conv_run) |-> ##[1:4] s_fetch_top)
        else $error("restart did not fetch the top entry");
    AST_REQ_HOLD: assert property (
        mem_req && !mem_ack && !$past(ab_ph) |=> mem_req && $stable(mem_index))
        else $error("fetch request dropped or moved before answer");
    AST_OPTIONS: assert property (
        mem_req && mem_ack && clk_en |=> cmd_options == rd_q[31:28]
        && int_channel == {rd_q[7], rd_q[7] ? rd_q[2:0] : 3'h0})
        else $error("command fields not taken from fetched word");
    AST_ABORT: assert property (
        s_flow(4'h4) ##0 conv_run |-> ##[1:4] !conv_run)
        else $error("abort did not stop the sequence");
    AST_RES: assert property (resolution != 2'h3)
        else $error("resolution outside the three settings");
    AST_IRQ_ONE: assert property ($onehot0(conv_irq))
        else $error("more than one conversion interrupt at once");
    AST_EOL_PULSE: assert property (
        eol_irq && !eol_done |=> !eol_irq)
        else $error("end of list interrupt longer than a pulse");
endmodule
`default_nettype wire

// >>> tb/alfc_conv_partner.sv
// Command memory and converter stand-in on the far side of the block
`timescale 1ns/10ps
`default_nettype none
module alfc_conv_partner #(
    parameter int ACK_DELAY = 8
) (
    input wire logic hclk, // Bus clock
    input wire logic hresetn, // Reset, active low
    input wire logic mem_req, // Fetch request
    input wire logic [6:0] mem_index, // Fetch index
    input wire logic conv_run, // Sequence running
    output logic mem_ack, // Fetch answer
    output logic [31:0] mem_rdata, // Fetched word
    output logic conv_boundary, // Boundary pulse
    output logic conv_done, // Result pulse
    output logic [3:0] conv_irq_sel, // Result interrupt index
    output logic eol_done // End of list pulse
);
    int cnt;
    logic [4:0] tick;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0000_0000;
            tick <= 5'h00;
            conv_boundary <= 1'b0;
            conv_done <= 1'b0;
            conv_irq_sel <= 4'h0;
            eol_done <= 1'b0;
        end else begin
            mem_ack <= 1'b0;
            // Data toggles outside the answer so stale values never pass
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                cnt <= cnt + 1;
                if (cnt == ACK_DELAY) begin
                    cnt <= 0;
                    mem_ack <= 1'b1;
                    mem_rdata <= {4'hA, 20'h00000, mem_index, 1'b1};
                end
            end else begin
                cnt <= 0;
            end
            tick <= conv_run ? tick + 5'h01 : 5'h00;
            conv_boundary <= conv_run && tick[1:0] == 2'h3;
            conv_done <= conv_run && tick[1:0] == 2'h3;
            conv_irq_sel <= {1'b0, tick[4:2]};
            eol_done <= conv_run && tick == 5'h1F;
        end
    end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the converter flow control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp;
    logic if_restart, if_trigger, if_seq_abort, if_load_ok;
    logic conv_boundary, eol_done, conv_done, mem_ack, mem_req, mem_src_nvm;
    logic conv_run, conv_halt, left_justify, result_buf, eol_irq;
    logic [11:0] haddr;
    logic [1:0] htrans, resolution;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, mem_rdata;
    logic [3:0] conv_irq_sel, cmd_options, int_channel;
    logic [6:0] mem_index;
    logic [14:0] conv_irq;
    int n_fail, checked;
    assign hready = hreadyout;
    alfc_flow_ctrl alfc_flow_ctrl_inst (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .if_restart,
        .if_trigger, .if_seq_abort, .if_load_ok, .conv_boundary, .eol_done, .conv_irq_sel,
        .conv_done, .mem_ack, .mem_rdata, .mem_req, .mem_src_nvm, .mem_index, .conv_run,
        .conv_halt, .resolution, .left_justify, .cmd_options, .int_channel, .result_buf,
        .conv_irq, .eol_irq);
    alfc_conv_partner #(.ACK_DELAY(8)) alfc_conv_partner_inst (.hclk, .hresetn, .mem_req,
        .mem_index, .conv_run, .mem_ack, .mem_rdata, .conv_boundary, .conv_done,
        .conv_irq_sel, .eol_done);
    // ------------------------------------------
    // Bus and check tasks
    // ------------------------------------------
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int k;
        k = 0;
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a;
        @(posedge hclk);
        while (hready !== 1'b1 && k < 50) begin @(posedge hclk); k++; end
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1 && k < 100) begin @(posedge hclk); k++; end
        r = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] mk, input logic [31:0] e,
        input string m);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        chk(r & mk, e, m);
    endtask
    // Waits until fetch and run have both been quiet for four cycles
    task automatic idle;
        int k, q;
        k = 0; q = 0;
        while (q < 4 && k < 300) begin
            @(posedge hclk); k++;
            q = (mem_req === 1'b0 && conv_run === 1'b0) ? q + 1 : 0;
        end
    endtask
    // ------------------------------------------
    // Scenarios
    // ------------------------------------------
    task automatic t_reset;
        rdchk(12'h000, 32'hFFFF_FFFF, 32'h0, "control after reset");
        rdchk(12'h008, 32'hFFFF_FFFF, 32'h0, "status after reset");
        rdchk(12'h00C, 32'hFFFF_FFFF, 32'h0, "errors after reset");
        rdchk(12'h020, 32'hFFFF_FFFF, 32'h0, "unmapped read");
    endtask
    task automatic t_swap;
        wr(12'h004, 32'h9);
        rdchk(12'h008, 32'h81, 32'h81, "restart with load-ok swaps list");
        idle();
    endtask
    task automatic t_overrun;
        wr(12'h004, 32'h1); wr(12'h004, 32'h9);
        rdchk(12'h008, 32'h31, 32'h31, "overrun held with load-ok");
        rdchk(12'h00C, 32'h2, 32'h2, "restart overrun error");
        idle();
        rdchk(12'h008, 32'h37, 32'h0, "held restart served and cleared");
        wr(12'h00C, 32'h7);
        rdchk(12'h00C, 32'h7, 32'h0, "errors cleared");
    endtask
    task automatic t_trigger_pending_flag;
        int k;
        wr(12'h000, 32'h1); wr(12'h004, 32'h1);
        rdchk(12'h008, 32'h3, 32'h3, "restart sets trigger pending");
        k = 0;
        while (conv_run !== 1'b1 && k < 60) begin @(posedge hclk); k++; end
        chk(conv_run, 32'h1, "sequence runs after fetch");
        wr(12'h004, 32'h4); wr(12'h004, 32'h4);
        idle();
        rdchk(12'h008, 32'h7, 32'h0, "abort clears pending flags");
        wr(12'h004, 32'h1); wr(12'h004, 32'h1);
        rdchk(12'h00C, 32'h1, 32'h0, "restart overrun is no trigger error");
        wr(12'h004, 32'h2);
        rdchk(12'h00C, 32'h1, 32'h1, "trigger overrun");
        wr(12'h00C, 32'h7); wr(12'h004, 32'h4); idle();
        wr(12'h004, 32'h3);
        rdchk(12'h00C, 32'h1, 32'h1, "automatic trigger collision");
        chk(conv_halt, 32'h1, "halt before sampling");
        wr(12'h004, 32'h4); idle(); wr(12'h00C, 32'h7);
    endtask
    task automatic t_rmode;
        wr(12'h000, 32'h0); wr(12'h004, 32'h3);
        rdchk(12'h00C, 32'h1, 32'h1, "restart with trigger in restart mode");
        wr(12'h004, 32'h1); wr(12'h004, 32'h5);
        rdchk(12'h00C, 32'h6, 32'h0, "abort suppresses restart errors");
        idle(); wr(12'h00C, 32'h7);
    endtask
    task automatic t_ctrl;
        for (int i = 0; i < 4; i++) begin
            wr(12'h000, (i << 1) | ((i & 1) << 3) | ((i >> 1) << 4));
            repeat (2) @(posedge hclk);
            chk(resolution, (i == 3) ? 32'h2 : i, "resolution select");
            chk(left_justify, i & 1, "justification");
            chk(mem_src_nvm, i >> 1, "fetch source");
        end
        wr(12'h000, 32'h0);
    endtask
    task automatic t_if;
        if_load_ok <= 1'b1; if_restart <= 1'b1;
        repeat (8) @(posedge hclk);
        if_restart <= 1'b0;
        chk(mem_req, 32'h1, "interface restart fetches");
        if_load_ok <= 1'b0;
        idle();
    endtask
    task automatic give_verdict;
        $display("Summary: %0d comparisons, %0d mismatches", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial begin
        n_fail = 0; checked = 0; hresetn = 1'b0; clk_en = 1'b1; hsel = 1'b0;
        haddr = 12'h000; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
        if_restart = 1'b0; if_trigger = 1'b0; if_seq_abort = 1'b0; if_load_ok = 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset(); t_swap(); t_overrun(); t_trigger_pending_flag(); t_rmode(); t_ctrl(); t_if();
        give_verdict();
    end
    // Scenarios need a few hundred cycles; the 8000-cycle limit leaves wide margin
    initial begin
        #200000;
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule
bind alfc_flow_ctrl alfc_flow_ctrl_properties alfc_flow_ctrl_properties_inst (.hclk, .hresetn,
    .clk_en, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .mem_ack,
    .mem_rdata, .mem_req, .mem_index, .conv_run, .resolution, .cmd_options, .int_channel,
    .conv_irq, .eol_done, .eol_irq);
`default_nettype wire
